// ---- bitjump_pkg.sv ----
/*
 * Shared constants and carriers for the bit modify and jump decoder.
 * Assumes one synchronous memory bus and machine cycles counted in clock states.
 */
package bitjump_pkg;

    // Prefix and opcode bytes
    localparam logic [7:0] OP_BIT_PREFIX = 8'hcb;
    localparam logic [7:0] OP_IDX1_PREFIX = 8'hdd;
    localparam logic [7:0] OP_IDX2_PREFIX = 8'hfd;
    localparam logic [7:0] OP_ABS_BRANCH = 8'hc3;
    localparam logic [7:0] OP_REL_BRANCH = 8'h18;
    localparam logic [7:0] ABS_COND_MASK = 8'hc7;
    localparam logic [7:0] ABS_COND_CODE = 8'hc2;
    localparam logic [7:0] REL_COND_MASK = 8'he7;
    localparam logic [7:0] REL_COND_CODE = 8'h20;

    // Bit-manipulation group field (opcode bits 7:6)
    localparam logic [1:0] GRP_CLEAR = 2'h2;
    localparam logic [1:0] GRP_SET = 2'h3;

    // Register codes; code 110 means the byte at the pointer pair
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;

    // Flag bit positions in the flag register
    localparam int FLAG_SIGN = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_CARRY = 0;

    // Clock states per machine cycle kind
    localparam logic [2:0] T_OPFETCH = 3'h4;
    localparam logic [2:0] T_MEMREAD = 3'h3;
    localparam logic [2:0] T_IDXOP = 3'h5;
    localparam logic [2:0] T_RMW_READ = 3'h4;
    localparam logic [2:0] T_MEMWRITE = 3'h3;
    localparam logic [2:0] T_REL_ADD = 3'h5;

    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'hffff;
    localparam logic [7:0] BYTE_RESET = 8'hff;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] h;
        logic [7:0] l;
        logic [7:0] a;
        logic [7:0] f;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
        logic [15:0] pc;
    } cpu_regs_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
        logic m1;
    } mem_req_s;

endpackage

// ---- bit_modify_and_jump_decode.sv ----
/*
 * Execute core for bit set and clear forms and the absolute and relative branches.
 * Assumes memory answers a read within the machine cycle; read data is sampled on
 * the last clock state of that cycle. Any other unprefixed opcode runs as a four-state no-op.
 */
// Functional notes
// - Bit-set via first index: address is index plus signed byte, 6 cycles, 23 states.
// - Second index form decodes FD, CB, displacement, then 11 bbb 110.
// - Bit selector 000 picks bit 0, 111 picks bit 7.
// - Bit-clear is CB then 10 bbb rrr; 110 means byte at pointer pair.
// - Register codes B..L are 000..101, A is 111, 110 is memory.
// - Bit-clear takes 8, 15, or 23 states for register, pointer, indexed.
// - None of these instructions alter any flag.
// - Absolute target: first operand byte is low, second is high.
// - Unconditional absolute branch loads PC, 3 cycles, 10 states.
// - Conditional absolute branch loads PC only if true, 10 states always.
// - Condition codes: NZ, Z, NC, C, PO, PE, P, M for 000..111.
// - Opcode 18 adds signed byte to PC past both bytes, 12 states.
// - Relative targets span -126 to +129 from the opcode address.
// - Carry-conditional relative branch jumps only when carry is one.
// - Untaken conditional relative branch takes 7 states, taken takes 12.
`timescale 1ns/1ps

module bit_modify_and_jump_decode
    import bitjump_pkg::*;
#(
    parameter int TSTATE_DIV = 1
) (
    input wire logic clk_i,              // Core clock
    input wire logic reset_i,            // Async reset, active high
    input wire logic regs_load_i,        // Pulse: load register image
    input wire cpu_regs_s regs_load_val_i, // Register image to load
    input wire logic [7:0] mem_rdata_i,  // Memory read data
    output mem_req_s mem_o,              // Memory request
    output cpu_regs_s regs_o,            // Current register image
    output logic insn_done_o,            // Pulse at instruction end
    output logic tstate_o                // Clock-state enable pulse
);

    typedef enum {
        S_OPCODE,
        S_PREFIX,
        S_BITOP,
        S_IDX_DISP,
        S_IDX_OP,
        S_RMW_READ,
        S_RMW_WRITE,
        S_ABS_LO,
        S_ABS_HI,
        S_REL_DISP,
        S_REL_ADD
    } mstate_e;

    // A zero divider ticks only once per 65536 clocks; above 16 bits the divider counter would wrap early
    if (TSTATE_DIV < 1 || TSTATE_DIV > 65535) begin
        $error("TSTATE_DIV out of range");
    end

    mstate_e state_reg, state_next;
    logic [15:0] div_reg;
    logic [2:0] tcnt_reg;
    logic [7:0] gpr_reg [8];
    // Index registers are kept apart from the byte file
    logic [15:0] first_index_reg, second_index_reg;
    logic [15:0] pc_reg;
    logic [15:0] ea_reg;
    logic [7:0] lo_reg, op_reg, mdata_reg;
    logic [1:0] idx_reg;
    logic cond_reg;
    logic [15:0] pc_next;

    wire logic tick = (div_reg == 16'h0000);
    logic [2:0] cyc_len;
    wire logic cyc_end = tick && (tcnt_reg == cyc_len - 3'h1);

    // Machine cycle length by state; these set every documented total
    always_comb begin
        unique case (state_reg)
            S_OPCODE, S_PREFIX, S_BITOP: cyc_len = T_OPFETCH;
            S_IDX_DISP, S_ABS_LO, S_ABS_HI, S_REL_DISP: cyc_len = T_MEMREAD;
            S_IDX_OP: cyc_len = T_IDXOP;
            S_RMW_READ: cyc_len = T_RMW_READ;
            S_RMW_WRITE: cyc_len = T_MEMWRITE;
            S_REL_ADD: cyc_len = T_REL_ADD;
        endcase
    end

    // Condition evaluation from flags only; flags are written only by a preset
    // One evaluator function serves both branch kinds, instanced once for each with its own condition field
    function automatic logic cond_true(input logic [2:0] condition_field, input logic [7:0] f);
        logic flag;
        flag = 1'b0;
        unique case (condition_field[2:1])
            2'h0: flag = f[FLAG_ZERO];
            2'h1: flag = f[FLAG_CARRY];
            2'h2: flag = f[FLAG_PARITY];
            2'h3: flag = f[FLAG_SIGN];
        endcase
        return flag == condition_field[0];
    endfunction

    // Opcode decoding of the byte arriving now
    wire logic [7:0] rd = mem_rdata_i;
    wire logic is_abs = (rd == OP_ABS_BRANCH);
    wire logic is_abs_cond = ((rd & ABS_COND_MASK) == ABS_COND_CODE);
    wire logic is_rel = (rd == OP_REL_BRANCH);
    wire logic is_rel_cond = ((rd & REL_COND_MASK) == REL_COND_CODE);
    wire logic abs_cond_ok = cond_true(rd[5:3], gpr_reg[REG_MEM]);
    // Relative conditions only use NZ/Z/NC/C, the low two bits of the code
    wire logic rel_cond_ok = cond_true({1'b0, rd[4:3]}, gpr_reg[REG_MEM]);
    wire logic is_modify = (rd[7:6] == GRP_SET) || (rd[7:6] == GRP_CLEAR);

    // Bit modification of a byte; selector maps straight to bit number
    function automatic logic [7:0] modify(input logic [7:0] v, input logic [7:0] op);
        logic [7:0] mask;
        mask = 8'h01 << op[5:3];
        return (op[7:6] == GRP_SET) ? (v | mask) : (v & ~mask);
    endfunction

    wire logic [15:0] pointer_pair = {gpr_reg[REG_H], gpr_reg[REG_L]};
    wire logic [15:0] idx_base = (idx_reg == 2'h1) ? first_index_reg : second_index_reg;
    // Sign extension keeps backward offsets correct
    wire logic [15:0] disp_ext = {{8{rd[7]}}, rd};
    // PC wraps at 16 bits, as the address bus does
    wire logic [15:0] pc_inc = pc_reg + 16'h0001;

    // Next machine state and program counter
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        unique case (state_reg)
            S_OPCODE: begin
                // Any opcode not decoded below runs as a four-state no-op
                pc_next = pc_inc;
                if (rd == OP_BIT_PREFIX) begin
                    state_next = S_BITOP;
                end else if (rd == OP_IDX1_PREFIX || rd == OP_IDX2_PREFIX) begin
                    state_next = S_PREFIX;
                end else if (is_abs || is_abs_cond) begin
                    state_next = S_ABS_LO;
                end else if (is_rel || is_rel_cond) begin
                    state_next = S_REL_DISP;
                end
            end
            S_PREFIX: begin
                // A prefix without the bit group costs eight states and does nothing
                pc_next = pc_inc;
                state_next = (rd == OP_BIT_PREFIX) ? S_IDX_DISP : S_OPCODE;
            end
            S_BITOP: begin
                pc_next = pc_inc;
                if (is_modify && rd[2:0] == REG_MEM) begin
                    state_next = S_RMW_READ;
                end else begin
                    state_next = S_OPCODE;
                end
            end
            S_IDX_DISP: begin
                pc_next = pc_inc;
                state_next = S_IDX_OP;
            end
            S_IDX_OP: begin
                // Non-modify groups stop here with no memory access
                pc_next = pc_inc;
                state_next = is_modify ? S_RMW_READ : S_OPCODE;
            end
            S_RMW_READ: state_next = S_RMW_WRITE;
            S_RMW_WRITE: state_next = S_OPCODE;
            S_ABS_LO: begin
                pc_next = pc_inc;
                state_next = S_ABS_HI;
            end
            S_ABS_HI: begin
                // Untaken still costs the full operand read
                pc_next = cond_reg ? {rd, lo_reg} : pc_inc;
                state_next = S_OPCODE;
            end
            S_REL_DISP: begin
                pc_next = pc_inc;
                // Untaken ends right after the displacement read
                state_next = cond_reg ? S_REL_ADD : S_OPCODE;
            end
            S_REL_ADD: begin
                // Adds to PC already past both bytes
                pc_next = pc_reg + {{8{lo_reg[7]}}, lo_reg};
                state_next = S_OPCODE;
            end
        endcase
    end

    // Clock-state divider and counter
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_reg <= 16'h0000;
            tcnt_reg <= 3'h0;
        end else if (regs_load_i) begin
            // A preset restarts the machine cycle too, so the first fetch is a full one
            div_reg <= 16'h0000;
            tcnt_reg <= 3'h0;
        end else begin
            div_reg <= (div_reg == 16'(TSTATE_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
            if (cyc_end) begin
                tcnt_reg <= 3'h0;
            end else if (tick) begin
                tcnt_reg <= tcnt_reg + 3'h1;
            end
        end
    end

    // Sequencer and program counter
    // A preset overrides any cycle end that falls in the same clock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= S_OPCODE;
            pc_reg <= PC_RESET;
        end else if (regs_load_i) begin
            state_reg <= S_OPCODE;
            pc_reg <= regs_load_val_i.pc;
        end else if (cyc_end) begin
            state_reg <= state_next;
            pc_reg <= pc_next;
        end
    end

    // Operand capture: prefix, condition, displacement, address, data
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            idx_reg <= 2'h0;
            cond_reg <= 1'b0;
            lo_reg <= 8'h00;
            op_reg <= 8'h00;
            ea_reg <= 16'h0000;
            mdata_reg <= 8'h00;
        end else if (cyc_end) begin
            unique case (state_reg)
                S_OPCODE: begin
                    idx_reg <= (rd == OP_IDX1_PREFIX) ? 2'h1 : 2'h2;
                    // Condition settles once, from the flags at fetch
                    cond_reg <= is_abs || is_rel || (is_abs_cond && abs_cond_ok) || (is_rel_cond && rel_cond_ok);
                    ea_reg <= pointer_pair;
                end
                S_BITOP: op_reg <= rd;
                S_IDX_DISP: ea_reg <= idx_base + disp_ext;
                S_IDX_OP: op_reg <= rd;
                S_RMW_READ: mdata_reg <= modify(rd, op_reg);
                S_ABS_LO, S_REL_DISP: lo_reg <= rd;
                S_PREFIX, S_RMW_WRITE, S_ABS_HI, S_REL_ADD: ;
            endcase
        end
    end

    // Register file; index 6 holds the flags, which only a preset writes
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 8; i++) begin
                gpr_reg[i] <= BYTE_RESET;
            end
            first_index_reg <= WORD_RESET;
            second_index_reg <= WORD_RESET;
        end else if (regs_load_i) begin
            gpr_reg[REG_B] <= regs_load_val_i.b;
            gpr_reg[REG_C] <= regs_load_val_i.c;
            gpr_reg[REG_D] <= regs_load_val_i.d;
            gpr_reg[REG_E] <= regs_load_val_i.e;
            gpr_reg[REG_H] <= regs_load_val_i.h;
            gpr_reg[REG_L] <= regs_load_val_i.l;
            gpr_reg[REG_MEM] <= regs_load_val_i.f;
            gpr_reg[REG_A] <= regs_load_val_i.a;
            first_index_reg <= regs_load_val_i.first_index_register;
            second_index_reg <= regs_load_val_i.second_index_register;
        end else if (cyc_end && state_reg == S_BITOP && is_modify && rd[2:0] != REG_MEM) begin
            // Code 110 is kept out, so the flag slot can never take a result
            gpr_reg[rd[2:0]] <= modify(gpr_reg[rd[2:0]], rd);
        end
    end

    // Bus request; write returns to the address that was read
    // Address comes from flops, so it stands for the whole machine cycle
    wire logic is_fetch = (state_reg == S_OPCODE) || (state_reg == S_PREFIX) || (state_reg == S_BITOP);
    wire logic is_rmw = (state_reg == S_RMW_READ) || (state_reg == S_RMW_WRITE);
    assign mem_o.addr = is_rmw ? ea_reg : pc_reg;
    assign mem_o.wdata = mdata_reg;
    assign mem_o.rd = (state_reg != S_RMW_WRITE) && (state_reg != S_REL_ADD);
    assign mem_o.wr = (state_reg == S_RMW_WRITE);
    assign mem_o.m1 = is_fetch;

    // Register image; flags pass through untouched
    assign regs_o.b = gpr_reg[REG_B];
    assign regs_o.c = gpr_reg[REG_C];
    assign regs_o.d = gpr_reg[REG_D];
    assign regs_o.e = gpr_reg[REG_E];
    assign regs_o.h = gpr_reg[REG_H];
    assign regs_o.l = gpr_reg[REG_L];
    assign regs_o.a = gpr_reg[REG_A];
    assign regs_o.f = gpr_reg[REG_MEM];
    assign regs_o.first_index_register = first_index_reg;
    assign regs_o.second_index_register = second_index_reg;
    assign regs_o.pc = pc_reg;

    // Masked on a preset so the restarted fetch is not counted twice
    assign insn_done_o = cyc_end && (state_next == S_OPCODE) && !regs_load_i;
    assign tstate_o = tick;

endmodule

// ---- mem_model.sv ----
/*
 * Behavioural memory on the far side of the core's bus.
 * Assumes zero-wait reads and a write that stands for the whole write cycle.
 */
`timescale 1ns/1ps
module mem_model
    import bitjump_pkg::*;
(
    input wire logic clk_i,     // Core clock
    input wire mem_req_s mem_i, // Request from the core
    output logic [7:0] rdata_o  // Read data back to the core
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg;

    // Idle bus shows a flipping pattern so stale data never passes as valid
    assign rdata_o = mem_i.rd ? mem[mem_i.addr] : ~last_reg;

    // Repeated stores in one write cycle are harmless, the data stands
    always @(posedge clk_i) begin
        if (mem_i.wr) begin
            mem[mem_i.addr] <= mem_i.wdata;
        end
        last_reg <= rdata_o;
    end

    // Empty memory decodes as four-state no-ops
    initial begin
        last_reg = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
    end
endmodule

// ---- bitjump_sva.sv ----
/*
 * Port checker for the bit modify and jump core.
 * Assumes one clock domain and the asynchronous active-high reset.
 */
`timescale 1ns/1ps
module bitjump_sva
    import bitjump_pkg::*;
#(
    parameter int TSTATE_DIV = 1
) (
    input wire logic clk_i,              // Core clock
    input wire logic reset_i,            // Async reset
    input wire logic regs_load_i,        // Register preset strobe
    input wire cpu_regs_s regs_load_val_i, // Preset image
    input wire logic [7:0] mem_rdata_i,  // Memory read data
    input wire mem_req_s mem_o,          // Memory request
    input wire cpu_regs_s regs_o,        // Register image
    input wire logic insn_done_o,        // Instruction end pulse
    input wire logic tstate_o            // Clock-state enable
);
    default clocking cb_def @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // Write cycle of three states, then the bus lets go
    sequence s_write3;
        mem_o.wr [*3] ##1 !mem_o.wr;
    endsequence
    // Shortest instruction is four states, so no done for three cycles
    sequence s_quiet3;
        !insn_done_o [*3];
    endsequence

    AST_FLAGS_KEPT: assert property (!regs_load_i |=> $stable(regs_o.f))
        else $error("flag register changed");
    AST_FETCH_READS: assert property (mem_o.m1 |-> mem_o.rd && !mem_o.wr)
        else $error("opcode fetch is not a read");
    AST_RD_WR_APART: assert property (!(mem_o.rd && mem_o.wr))
        else $error("read and write at once");
    AST_WRITE_LEN: assert property ($rose(mem_o.wr) |-> s_write3)
        else $error("write cycle not three states");
    AST_WRITE_SAME_ADDR: assert property ($rose(mem_o.wr) |-> $past(mem_o.rd) && $stable(mem_o.addr))
        else $error("write not at the address just read");
    AST_WRITE_ONE_BIT: assert property ($rose(mem_o.wr) |-> $countones(mem_o.wdata ^ $past(mem_rdata_i)) <= 1)
        else $error("write back changed more than one bit");
    AST_DONE_SPACING: assert property (insn_done_o |=> s_quiet3)
        else $error("instruction shorter than four states");
    AST_PRESET_LOAD: assert property (regs_load_i |=> regs_o == $past(regs_load_val_i) && mem_o.m1)
        else $error("preset image not loaded");
endmodule

bind bit_modify_and_jump_decode bitjump_sva #(.TSTATE_DIV(TSTATE_DIV)) sva_u (
    .clk_i(clk_i), .reset_i(reset_i), .regs_load_i(regs_load_i), .regs_load_val_i(regs_load_val_i),
    .mem_rdata_i(mem_rdata_i), .mem_o(mem_o), .regs_o(regs_o), .insn_done_o(insn_done_o), .tstate_o(tstate_o)
);

// ---- tb.sv ----
/*
 * Self-checking bench: each instruction runs behind a no-op and is timed done to done.
 * Assumes the memory model answers reads at once.
 */
`timescale 1ns/1ps
module tb;
    import bitjump_pkg::*;
    logic clk_i, reset_i, regs_load_i, insn_done_o, tstate_o;
    cpu_regs_s regs_load_val_i, regs_o, img;
    mem_req_s mem_o;
    logic [7:0] mem_rdata_i;
    int num_errors, check_count;

    bit_modify_and_jump_decode #(.TSTATE_DIV(1)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
        .regs_load_i(regs_load_i), .regs_load_val_i(regs_load_val_i), .mem_rdata_i(mem_rdata_i),
        .mem_o(mem_o), .regs_o(regs_o), .insn_done_o(insn_done_o), .tstate_o(tstate_o));
    mem_model mem_u (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

    // 4 ns clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Places a no-op then the instruction at a; times done to done, then the next fetch
    task automatic run(input logic [15:0] a, input logic [7:0] b0, b1, b2, b3,
                       input int exp_t, input logic [15:0] nxt);
        int n;
        mem_u.mem[a - 16'h1] = 8'h00;
        mem_u.mem[a] = b0;
        mem_u.mem[a + 16'h1] = b1;
        mem_u.mem[a + 16'h2] = b2;
        mem_u.mem[a + 16'h3] = b3;
        img.pc = a - 16'h1;
        @(posedge clk_i);
        regs_load_i <= 1'b1;
        regs_load_val_i <= img;
        @(posedge clk_i);
        regs_load_i <= 1'b0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (insn_done_o !== 1'b1 && n < 200);
        n = 0;
        do begin @(negedge clk_i); n++; end while (insn_done_o !== 1'b1 && n < 200);
        check(64'(n), 64'(exp_t));
        @(negedge clk_i);
        check({mem_o.m1, mem_o.addr}, {1'b1, nxt});
        check(regs_o.f, img.f);
    endtask

    // Reset image, first fetch at address zero, state pulse high on the first clock checked when undivided
    task automatic t_reset();
        @(negedge clk_i);
        check(regs_o[111:48], {8{BYTE_RESET}});
        check(regs_o[47:0], {WORD_RESET, WORD_RESET, PC_RESET});
        check({mem_o.m1, mem_o.rd, mem_o.wr, mem_o.addr}, {3'b110, PC_RESET});
        check(tstate_o, 1'b1);
    endtask

    task automatic t_abs_branch();
        run(16'h1001, 8'hc3, 8'h34, 8'h12, 8'h00, 10, 16'h1234);
    endtask

    // Every condition code, once with all flags clear and once with all set
    task automatic t_abs_cond();
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 2; v++) begin
                img.f = v ? 8'hff : 8'h00;
                run(16'h2001, {2'b11, 3'(c), 3'b010}, 8'h78, 8'h56, 8'h00, 10,
                    (c % 2 == v) ? 16'h5678 : 16'h2004);
            end
        end
    endtask

    // Both ends of the displacement range
    task automatic t_rel_branch();
        img.f = 8'h00;
        run(16'h3001, 8'h18, 8'h7f, 8'h00, 8'h00, 12, 16'h3082);
        run(16'h3001, 8'h18, 8'h80, 8'h00, 8'h00, 12, 16'h2f83);
    endtask

    task automatic t_rel_carry();
        img.f = 8'h01;
        run(16'h4001, 8'h38, 8'h10, 8'h00, 8'h00, 12, 16'h4013);
        img.f = 8'h00;
        run(16'h4001, 8'h38, 8'h10, 8'h00, 8'h00, 7, 16'h4003);
    endtask

    // Set on zeroed and clear on filled registers, one bit per register code
    task automatic t_bitreg();
        logic [63:0] exp;
        logic [7:0] iv;
        int b;
        int k;
        for (int g = 2; g < 4; g++) begin
            for (int r = 0; r < 8; r++) begin
                if (r != 6) begin
                    iv = (g == 3) ? 8'h00 : 8'hff;
                    b = (g == 3) ? r : 7 - r;
                    k = (r == 7) ? 6 : r;
                    img[111:48] = {8{iv}};
                    exp = {8{iv}};
                    exp[63 - 8 * k -: 8] = iv ^ (8'h01 << b);
                    run(16'h5001, 8'hcb, {2'(g), 3'(b), 3'(r)}, 8'h00, 8'h00, 8, 16'h5003);
                    check(regs_o[111:48], exp);
                end
            end
        end
    endtask

    // Memory forms: pointer pair, first index below base, second index both ways
    task automatic t_bitmem();
        img.h = 8'h30;
        img.l = 8'h00;
        img.first_index_register = 16'h2000;
        img.second_index_register = 16'h2100;
        mem_u.mem[16'h3000] = 8'hff;
        run(16'h6001, 8'hcb, 8'hbe, 8'h00, 8'h00, 15, 16'h6003);
        check(mem_u.mem[16'h3000], 8'h7f);
        mem_u.mem[16'h1ffe] = 8'h00;
        run(16'h7001, 8'hdd, 8'hcb, 8'hfe, 8'hee, 23, 16'h7005);
        check(mem_u.mem[16'h1ffe], 8'h20);
        mem_u.mem[16'h217f] = 8'hff;
        run(16'h8001, 8'hfd, 8'hcb, 8'h7f, 8'h8e, 23, 16'h8005);
        check(mem_u.mem[16'h217f], 8'hfd);
        mem_u.mem[16'h2080] = 8'h00;
        run(16'h8001, 8'hfd, 8'hcb, 8'h80, 8'hd6, 23, 16'h8005);
        check(mem_u.mem[16'h2080], 8'h04);
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_i = 1'b1;
        regs_load_i = 1'b0;
        regs_load_val_i = '0;
        img = '0;
        num_errors = 0;
        check_count = 0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_abs_branch();
        t_abs_cond();
        t_rel_branch();
        t_rel_carry();
        t_bitreg();
        t_bitmem();
        conclude();
    end

    // Whole run needs well under 2000 cycles; a hang ends here
    initial begin
        #40000;
        num_errors++;
        conclude();
    end
endmodule
